// ===== design/dac_serial_host.sv
`timescale 1ns/1ps

module dac_serial_host
  import dac_link_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   srst,
  dac_link_if.host    link,
  input  wire logic   wr_valid,
  output logic        wr_ready,
  input  wire word_t  wr_data,
  input  wire logic   lsb_first,
  input  wire logic   auto_load,
  output logic        busy
);
  logic      f_valid;
  word_t     f_data;
  logic      pop;
  tx_state_t state_r;
  tx_state_t state_nxt;
  logic [7:0] div_r;
  logic [`CNT_BITS-1:0] cnt_r;
  word_t     shift_r;
  logic      sclk_r;
  logic      frame_n_r;
  logic      sdata_r;
  logic      ld_n_r;
  logic      busy_r;

  word_fifo #(.WIDTH(`WORD_BITS), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) word_fifo_inst (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  wire tick     = (div_r == `SCLK_HALF_DIV - 8'h01);
  wire last     = (cnt_r == `LAST_BIT - 5'h01);
  wire next_bit = lsb_first ? shift_r[1] : shift_r[14];
  assign pop = (state_r == TX_IDLE) && f_valid && tick;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TX_IDLE: if (pop) state_nxt = TX_HIGH;
      TX_HIGH: if (tick) state_nxt = TX_LOW;
      TX_LOW:  if (tick) state_nxt = last ? TX_END : TX_HIGH;
      TX_END:  if (tick) state_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r   <= TX_IDLE;
      div_r     <= '0;
      cnt_r     <= '0;
      shift_r   <= '0;
      sclk_r    <= 1'b1;
      frame_n_r <= 1'b1;
      sdata_r   <= 1'b0;
      ld_n_r    <= 1'b1;
      busy_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      div_r   <= tick ? 8'h00 : div_r + 8'h01;
      busy_r  <= (state_nxt != TX_IDLE);
      ld_n_r  <= auto_load ? 1'b0 : !(state_r == TX_END && tick);
      if (pop) begin
        shift_r   <= f_data;
        sdata_r   <= lsb_first ? f_data[0] : f_data[15];
        frame_n_r <= 1'b0;
        cnt_r     <= '0;
      end else if (state_r == TX_HIGH && tick) begin
        sclk_r <= 1'b0;
      end else if (state_r == TX_LOW && tick) begin
        sclk_r  <= 1'b1;
        cnt_r   <= cnt_r + 5'h01;
        shift_r <= lsb_first ? {1'b0, shift_r[15:1]} : {shift_r[14:0], 1'b0};
        sdata_r <= next_bit;
        if (last) begin
          frame_n_r <= 1'b1;
        end
      end
    end
  end

  assign link.sclk              = sclk_r;
  assign link.frame_n           = frame_n_r;
  assign link.sdata             = sdata_r;
  assign link.load_dac_strobe_n = ld_n_r;
  assign link.chip_sel_n        = 1'b0;
  assign busy                   = busy_r;
endmodule : dac_serial_host

// ===== design/dac_serial_word_loader.sv
`timescale 1ns/1ps
// Overview of operation
// - Host sends 16-bit words framed by active-low sync.
// - Load low: latch updates on sixteenth falling edge.
// - Host data valid at serial clock falling edge.
// - Rising-edge hosts invert clock before the device.
// - Order low, alignment high: LSB arrives first.
// - Order high, alignment low: MSB arrives first.
// - External timing logic drives load strobe synchronously.
// - Straps share parallel data bits eleven and ten.
// - Chip select tied low selects serial mode.

module dac_serial_word_loader
  import dac_link_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  dac_link_if.converter   link,
  input  wire logic       par_data_bit_eleven,
  input  wire logic       par_data_bit_ten,
  output dac_code_t       dac_code,
  output logic            dac_update,
  output word_t           input_word,
  output logic            word_done
);
  localparam logic [`SYNC_W-1:0] sync_idle = `SYNC_IDLE;

  logic [2:0]           clk_s_r;
  wire  [`SYNC_W-1:0]   pin_raw;
  wire  [`SYNC_W-1:0]   pin_sync;
  wire                  frm_n_s;
  wire                  ld_n_s;
  wire                  cs_n_s;
  wire                  dat_s;
  wire                  b11_s;
  wire                  b10_s;
  logic                 ld_prev_r;
  logic [`CNT_BITS-1:0] cnt_r;
  word_t                shift_r;
  word_t                shift_nxt;
  word_t                input_word_r;
  dac_code_t            dac_code_r;
  logic                 dac_update_r;
  logic                 word_done_r;
  logic                 order_r;
  logic                 align_r;

  // Reports a high-to-low change between two samples of a level.
  function automatic logic went_low(input logic prev, input logic now);
    went_low = prev && !now;
  endfunction : went_low

  // Bit order: frame, load strobe, chip select, data, straps.
  assign pin_raw = {link.frame_n, link.load_dac_strobe_n, link.chip_sel_n,
                    link.sdata, par_data_bit_eleven, par_data_bit_ten};

  genvar g;
  generate
    for (g = 0; g < `SYNC_W; g++) begin : g_sync
      logic meta_r;
      logic sync_r;

      always_ff @(posedge clk) begin
        if (srst) begin
          meta_r <= sync_idle[g];
        end else begin
          meta_r <= pin_raw[g];
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          sync_r <= sync_idle[g];
        end else begin
          sync_r <= meta_r;
        end
      end

      assign pin_sync[g] = sync_r;
    end
  endgenerate

  assign frm_n_s = pin_sync[5];
  assign ld_n_s  = pin_sync[4];
  assign cs_n_s  = pin_sync[3];
  assign dat_s   = pin_sync[2];
  assign b11_s   = pin_sync[1];
  assign b10_s   = pin_sync[0];

  // The serial clock idles high, so the stages reset high to avoid a false edge.
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_s_r <= `SCLK_IDLE;
    end else begin
      clk_s_r <= {clk_s_r[1:0], link.sclk};
    end
  end

  wire serial_mode = !cs_n_s;
  wire fall        = went_low(clk_s_r[2], clk_s_r[1]);
  wire framed      = !frm_n_s && serial_mode;
  wire take_bit    = fall && framed;
  wire last_bit    = take_bit && (cnt_r == `LAST_BIT - 5'h01);
  wire lsb_first   = !order_r && align_r;
  wire ld_low      = !ld_n_s;
  wire ld_rise     = went_low(!ld_prev_r, !ld_n_s);
  wire load_now    = last_bit && ld_low;
  wire dac_code_t word_code = input_word_r[`DAC_BITS-1:0];

  assign shift_nxt = lsb_first ? {dat_s, shift_r[15:1]}
                               : {shift_r[14:0], dat_s};

  always_ff @(posedge clk) begin
    if (srst) begin
      order_r <= 1'b1;
    end else if (serial_mode && !framed) begin
      order_r <= b11_s;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      align_r <= 1'b0;
    end else if (serial_mode && !framed) begin
      align_r <= b10_s;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
    end else if (!framed) begin
      cnt_r <= '0;
    end else if (take_bit) begin
      cnt_r <= last_bit ? '0 : cnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shift_r <= '0;
    end else if (take_bit) begin
      shift_r <= shift_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ld_prev_r <= 1'b1;
    end else begin
      ld_prev_r <= ld_n_s;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      word_done_r <= 1'b0;
    end else begin
      word_done_r <= last_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      input_word_r <= '0;
    end else if (last_bit) begin
      input_word_r <= shift_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dac_update_r <= 1'b0;
    end else begin
      dac_update_r <= load_now || ld_rise;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dac_code_r <= '0;
    end else if (load_now) begin
      dac_code_r <= shift_nxt[`DAC_BITS-1:0];
    end else if (ld_rise) begin
      dac_code_r <= word_code;
    end
  end

  assign dac_code   = dac_code_r;
  assign dac_update = dac_update_r;
  assign input_word = input_word_r;
  assign word_done  = word_done_r;
endmodule : dac_serial_word_loader

// ===== design/word_fifo.sv
`timescale 1ns/1ps

module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  wire              full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire              empty = (wr_ptr_r == rd_ptr_r);
  wire              push  = in_valid && !full;
  wire              pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end
endmodule : word_fifo

// ===== shared/dac_link_defs.svh
`ifndef DAC_LINK_DEFS_SVH
`define DAC_LINK_DEFS_SVH

`define WORD_BITS       16
`define DAC_BITS        14
`define CNT_BITS        5
`define LAST_BIT        5'h10
`define SCLK_HALF_DIV   8'h04
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define SYNC_W          6
`define SYNC_IDLE       6'h38
`define SCLK_IDLE       3'h7

`endif

// ===== shared/dac_link_if.sv
`timescale 1ns/1ps

interface dac_link_if;
  logic sclk;
  logic frame_n;
  logic sdata;
  logic load_dac_strobe_n;
  logic chip_sel_n;

  modport converter (
    input sclk,
    input frame_n,
    input sdata,
    input load_dac_strobe_n,
    input chip_sel_n
  );

  modport host (
    output sclk,
    output frame_n,
    output sdata,
    output load_dac_strobe_n,
    output chip_sel_n
  );
endinterface : dac_link_if

// ===== shared/dac_link_pkg.sv
`include "dac_link_defs.svh"

package dac_link_pkg;
  typedef logic [`WORD_BITS-1:0] word_t;
  typedef logic [`DAC_BITS-1:0]  dac_code_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_HIGH = 2'b01,
    TX_LOW  = 2'b11,
    TX_END  = 2'b10
  } tx_state_t;
endpackage : dac_link_pkg

// ===== test/dac_link_asserts.sv
`timescale 1ns/1ps
`include "dac_link_defs.svh"

module dac_link_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdata,
  input wire logic load_dac_strobe_n,
  input wire logic chip_sel_n
);
  logic                 sclk_r;
  logic [`CNT_BITS-1:0] fall_cnt_r;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // Counts falling serial clock edges inside the current frame.
  always_ff @(posedge clk) begin
    sclk_r <= sclk;
    if (srst || frame_n) fall_cnt_r <= '0;
    else if (sclk_r && !sclk) fall_cnt_r <= fall_cnt_r + 1'b1;
  end

  serial_mode_a: assert property (!chip_sel_n)
    else $error("chip select left serial mode");
  frame_len_a: assert property ($rose(frame_n) |-> fall_cnt_r == `LAST_BIT)
    else $error("frame did not hold sixteen bits");
  frame_start_a: assert property ($fell(frame_n) |-> sclk)
    else $error("frame opened with clock low");
  frame_gap_a: assert property ($rose(frame_n) |-> frame_n [*4])
    else $error("gap between frames too short");
  idle_clock_a: assert property (frame_n && $past(frame_n) |-> $stable(sclk))
    else $error("serial clock moved outside a frame");
  data_hold_a: assert property (!frame_n && $fell(sclk) |-> $stable(sdata))
    else $error("data changed at capturing edge");
  half_period_a: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
    else $error("serial clock low phase wrong");
  strobe_idle_a: assert property ($fell(load_dac_strobe_n) |-> frame_n)
    else $error("load strobe fell inside a frame");
endmodule : dac_link_asserts

// ===== test/dac_serial_word_loader_tb.sv
`timescale 1ns/1ps

module dac_serial_word_loader_tb;
  import dac_link_pkg::*;
  logic      clk, srst, wr_valid, wr_ready, lsb_first, auto_load, busy;
  logic      par_data_bit_eleven, par_data_bit_ten, dac_update, word_done;
  word_t     wr_data, input_word;
  dac_code_t dac_code;
  word_t     words_q[$];
  dac_code_t codes_q[$];
  int        miscompares, compares;

  dac_link_if link_if ();
  dac_serial_host dac_serial_host_inst (.clk(clk), .srst(srst), .link(link_if.host),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .lsb_first(lsb_first),
    .auto_load(auto_load), .busy(busy));
  dac_serial_word_loader dac_serial_word_loader_inst (.clk(clk), .srst(srst),
    .link(link_if.converter), .par_data_bit_eleven(par_data_bit_eleven),
    .par_data_bit_ten(par_data_bit_ten), .dac_code(dac_code), .dac_update(dac_update),
    .input_word(input_word), .word_done(word_done));
  dac_link_asserts dac_link_asserts_inst (.clk(clk), .srst(srst), .sclk(link_if.sclk),
    .frame_n(link_if.frame_n), .sdata(link_if.sdata),
    .load_dac_strobe_n(link_if.load_dac_strobe_n), .chip_sel_n(link_if.chip_sel_n));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(negedge clk) begin
    if (word_done === 1'b1) words_q.push_back(input_word);
    if (dac_update === 1'b1) codes_q.push_back(dac_code);
  end

  task check(input word_t seen, input word_t exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task close_out;
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task wait_q(input int n);
    for (int i = 0; i < 8000 && codes_q.size() < n; i++) @(negedge clk);
    if (codes_q.size() < n) begin
      miscompares++;
      $display("CHECK FAILED %0t no latch update", $time);
      close_out();
    end
  endtask : wait_q

  task setup(input logic order, input logic align, input logic auto);
    par_data_bit_eleven = order;
    par_data_bit_ten = align;
    lsb_first = !order && align;
    auto_load = auto;
    repeat (16) @(negedge clk);
    words_q.delete();
    codes_q.delete();
  endtask : setup

  task send_one(input word_t w);
    for (int i = 0; i < 400 && !wr_ready; i++) @(negedge clk);
    wr_valid = 1'b1;
    wr_data = w;
    @(negedge clk);
    wr_valid = 1'b0;
    wait_q(1);
  endtask : send_one

  task t_msb_first;
    setup(1'b1, 1'b0, 1'b1);
    send_one(16'hA5C3);
    check(words_q[0], 16'hA5C3);
    check({2'h0, codes_q[0]}, 16'h25C3);
  endtask : t_msb_first

  task t_lsb_first;
    setup(1'b0, 1'b1, 1'b1);
    send_one(16'h3C5A);
    check(words_q[0], 16'h3C5A);
    check({2'h0, codes_q[0]}, 16'h3C5A);
  endtask : t_lsb_first

  task t_burst;
    int n;
    n = 0;
    setup(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 20; i++) begin
      if (!wr_ready) break;
      wr_valid = 1'b1;
      wr_data = word_t'(16'hC000 + i);
      n++;
      @(negedge clk);
    end
    check({15'h0, wr_ready}, 16'h0000);
    wr_valid = 1'b0;
    wait_q(n);
    for (int i = 0; i < n; i++) begin
      check(words_q[i], word_t'(16'hC000 + i));
      check({2'h0, codes_q[i]}, word_t'(i));
    end
  endtask : t_burst

  initial begin
    srst = 1'b1;
    wr_valid = 1'b0;
    wr_data = '0;
    lsb_first = 1'b0;
    auto_load = 1'b1;
    par_data_bit_eleven = 1'b1;
    par_data_bit_ten = 1'b0;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    t_msb_first();
    t_lsb_first();
    t_burst();
    close_out();
  end
endmodule : dac_serial_word_loader_tb
